// *** fepcs_pkg.sv ***
// Constants shared by the fast ethernet receive coding sublayer
package fepcs_pkg;
	// Clock rate and timing figures
	localparam int CLK_MHZ = 25;
	localparam int LINK_UP_TIME_US = 395;
	localparam int HOLD_TIME_US = 722;
	localparam int LINK_UP_CYCLES = LINK_UP_TIME_US * CLK_MHZ;
	localparam int HOLD_CYCLES = HOLD_TIME_US * CLK_MHZ;
	localparam int TIMER_WIDTH = 16;

	// Symbol framing
	localparam int GROUP_BITS = 5;
	localparam logic [2:0] GROUP_LAST = 3'h4;
	localparam int IDLE_LOCK_GROUPS = 12;
	localparam logic [5:0] LOCK_BITS = 6'(IDLE_LOCK_GROUPS * GROUP_BITS);
	localparam logic [5:0] HOLD_IDLE_BITS = 6'h3a;
	localparam logic [3:0] IDLE_PREFIX_BITS = 4'ha;
	localparam logic [3:0] CARRIER_LAST_BIT = 4'h6;

	// Code-groups and substituted nibbles
	localparam logic [4:0] CODE_J = 5'h18;
	localparam logic [4:0] CODE_K = 5'h11;
	localparam logic [4:0] CODE_T = 5'h0d;
	localparam logic [4:0] CODE_R = 5'h07;
	localparam logic [4:0] CODE_I = 5'h1f;
	localparam logic [4:0] CODE_H = 5'h04;
	localparam logic [3:0] PREAMBLE_NIBBLE = 4'h5;
	localparam logic [3:0] BAD_SSD_NIBBLE = 4'he;

	// Descrambler
	localparam int LFSR_WIDTH = 11;
	localparam int LFSR_TAP_HI = 10;
	localparam int LFSR_TAP_LO = 8;
	localparam logic [10:0] LFSR_RESET = 11'h7ff;

	// Coding sublayer configuration word
	localparam int CFG_WIDTH = 16;
	localparam int CFG_FORCE_SD_BIT = 1;
	localparam int CFG_LOCK_FOR_LINK_BIT = 8;

	// Counters and widths
	localparam int FC_WIDTH = 16;
	localparam int EQ_WIDTH = 8;

	typedef enum logic [1:0] {
		RX_IDLE,
		RX_CARRIER,
		RX_FRAME,
		RX_BAD
	} fepcs_rx_e;
endpackage

// *** fepcs_decode.sv ***
// Five-bit code-group to nibble lookup
`timescale 1ns/100ps
module fepcs_decode (
	input wire logic [4:0] code,
	output logic [3:0] nibble,
	output logic invalid
);
	// Data table; control and unused groups flag invalid
	always_comb begin
		invalid = 1'b0;
		unique case (code)
			5'h1e: nibble = 4'h0;
			5'h09: nibble = 4'h1;
			5'h14: nibble = 4'h2;
			5'h15: nibble = 4'h3;
			5'h0a: nibble = 4'h4;
			5'h0b: nibble = 4'h5;
			5'h0e: nibble = 4'h6;
			5'h0f: nibble = 4'h7;
			5'h12: nibble = 4'h8;
			5'h13: nibble = 4'h9;
			5'h16: nibble = 4'ha;
			5'h17: nibble = 4'hb;
			5'h1a: nibble = 4'hc;
			5'h1b: nibble = 4'hd;
			5'h1c: nibble = 4'he;
			5'h1d: nibble = 4'hf;
			default: begin
				nibble = 4'h0;
				invalid = 1'b1;
			end
		endcase
	end
endmodule

// *** fepcs_rx.sv ***
// Fast ethernet receive coding sublayer: decode, descramble, align, link monitor
//
// Notes on behaviour
// - Recovered 125 MHz line clock times all receive bit operations.
// - NRZI becomes NRZ, then goes to descrambler or straight to alignment.
// - Received bits are assembled into five-bit symbols for the receive state machine.
// - Descrambled bit is received bit XOR locally generated scrambler sequence bit.
// - Lock only after twelve consecutive unscrambled idle groups.
// - On lock, hold timer counts 722 us; 58 idle bits restart it.
// - Hold timer expiry drops lock, resets descrambler, starts reacquisition.
// - Start delimiter pair fixes the five-bit group boundary for following data.
// - Start delimiter after idles is replaced by two preamble nibbles 0101.
// - Groups decode to nibbles until end delimiter pair or two idles.
// - Standard table; halt and unused patterns decode as errors.
// - Descrambler and decoder each have a bypass passing raw code through.
// - Link up only after signal detect held continuously for 395 us.
// - Configuration bit 1 forces signal detect active.
// - Configuration bit 8 adds descrambler lock to link-up entry only.
// - Idle run followed by non-idle that is not start pair is bad.
// - Bad start delimiter drives receive error and nibble 1110 until two idles.
// - Each bad start delimiter adds exactly one to false-carrier counter.
// - Bad start delimiter pulses the false-carrier event after two idles.
// - Equalization amount is readable as a rough cable-length indication.
// - Normal and fast link pulses must not raise signal detect.
`timescale 1ns/100ps
module fepcs_rx #(
	parameter int LINK_UP_CYCLES = fepcs_pkg::LINK_UP_CYCLES,
	parameter int HOLD_CYCLES = fepcs_pkg::HOLD_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic lineClk,
	input wire logic lineData,
	input wire logic signalDetect,
	input wire logic [fepcs_pkg::CFG_WIDTH-1:0] codingSublayerConfig,
	input wire logic bypassDescrambler,
	input wire logic bypassDecoder,
	input wire logic [fepcs_pkg::EQ_WIDTH-1:0] eqLevel,
	output logic rxClk,
	output logic [3:0] rxd,
	output logic rxDv,
	output logic rxEr,
	output logic [4:0] codeOut,
	output logic codeStrobe,
	output logic descramblerLocked,
	output logic linkUp,
	output logic [fepcs_pkg::FC_WIDTH-1:0] falseCarrierCount,
	output logic falseCarrierEvent,
	output logic [fepcs_pkg::EQ_WIDTH-1:0] eqLevelOut
);
	localparam int TW = fepcs_pkg::TIMER_WIDTH;

	// Timer lengths must fit the counters
	if (LINK_UP_CYCLES < 1 || LINK_UP_CYCLES >= (1 << TW)) begin : gLinkCheck
		$error("LINK_UP_CYCLES out of range");
	end
	if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << TW)) begin : gHoldCheck
		$error("HOLD_CYCLES out of range");
	end

	localparam logic [TW-1:0] LINK_LAST = TW'(LINK_UP_CYCLES - 1);
	localparam logic [TW-1:0] HOLD_LAST = TW'(HOLD_CYCLES - 1);

	typedef struct packed {
		logic [1:0] clkSync;
		logic [1:0] dataSync;
		logic [1:0] sdSync;
		logic clkPrev;
		logic nrziPrev;
		logic [fepcs_pkg::LFSR_WIDTH-1:0] lfsr;
		logic [5:0] matchCnt;
		logic locked;
		logic [TW-1:0] holdCnt;
		logic [5:0] idleRun;
		logic [9:0] win;
		logic [3:0] onesRun;
		fepcs_pkg::fepcs_rx_e rxSt;
		logic [3:0] carrCnt;
		logic [2:0] bitCnt;
		logic [4:0] prevGroup;
		logic [3:0] pendRxd;
		logic pendDv;
		logic pendEr;
		logic [3:0] rxd;
		logic rxDv;
		logic rxEr;
		logic rxClk;
		logic [4:0] codeOut;
		logic codeStrobe;
		logic [TW-1:0] linkCnt;
		logic linkUp;
		logic [fepcs_pkg::FC_WIDTH-1:0] fcCount;
		logic fcEvent;
		logic [fepcs_pkg::EQ_WIDTH-1:0] eqSync1;
		logic [fepcs_pkg::EQ_WIDTH-1:0] eqSync2;
		logic [fepcs_pkg::EQ_WIDTH-1:0] eqPrev;
		logic [fepcs_pkg::EQ_WIDTH-1:0] eqOut;
	} fepcs_state_s;

	localparam fepcs_state_s ST_RESET = '{
		lfsr: fepcs_pkg::LFSR_RESET,
		rxSt: fepcs_pkg::RX_IDLE,
		default: '0
	};

	fepcs_state_s st_reg;
	fepcs_state_s st_next;

	logic bitStrobe;
	logic sd;
	logic nrz;
	logic scrSeq;
	logic ud;
	logic groupDone;
	logic [9:0] winNew;
	logic [4:0] group;
	logic [3:0] decNibble;
	logic decInvalid;
	logic holdLoad;

	// Lookup of the completed group
	fepcs_decode uDecode (
		.code(group),
		.nibble(decNibble),
		.invalid(decInvalid)
	);

	// Bit path from the line pins
	always_comb begin
		bitStrobe = st_reg.clkSync[1] & ~st_reg.clkPrev;
		sd = st_reg.sdSync[1] | codingSublayerConfig[fepcs_pkg::CFG_FORCE_SD_BIT];
		nrz = st_reg.dataSync[1] ^ st_reg.nrziPrev;
		scrSeq = st_reg.lfsr[fepcs_pkg::LFSR_TAP_HI] ^ st_reg.lfsr[fepcs_pkg::LFSR_TAP_LO];
		ud = bypassDescrambler ? nrz : (nrz ^ scrSeq);
		winNew = {st_reg.win[8:0], ud};
		group = winNew[4:0];
		groupDone = bitStrobe && (st_reg.bitCnt == fepcs_pkg::GROUP_LAST);
	end

	// Next state of the whole receiver
	always_comb begin
		st_next = st_reg;
		holdLoad = 1'b0;
		st_next.clkSync = {st_reg.clkSync[0], lineClk};
		st_next.dataSync = {st_reg.dataSync[0], lineData};
		st_next.sdSync = {st_reg.sdSync[0], signalDetect};
		st_next.clkPrev = st_reg.clkSync[1];
		st_next.codeStrobe = 1'b0;
		st_next.fcEvent = 1'b0;

		// Equalizer level taken only when two samples agree
		st_next.eqSync1 = eqLevel;
		st_next.eqSync2 = st_reg.eqSync1;
		st_next.eqPrev = st_reg.eqSync2;
		if (st_reg.eqSync2 == st_reg.eqPrev) begin
			st_next.eqOut = st_reg.eqPrev;
		end

		// Link monitor; qualification time rejects link pulse bursts
		if (!sd) begin
			st_next.linkCnt = '0;
			st_next.linkUp = 1'b0;
		end else if (!st_reg.linkUp) begin
			if (st_reg.linkCnt != LINK_LAST) begin
				st_next.linkCnt = st_reg.linkCnt + 1'b1;
			end else if (!codingSublayerConfig[fepcs_pkg::CFG_LOCK_FOR_LINK_BIT]
					|| st_reg.locked) begin
				st_next.linkUp = 1'b1;
			end
		end

		if (!sd) begin
			// Loss of signal clears descrambler and receive state; group counter holds
			st_next.lfsr = fepcs_pkg::LFSR_RESET;
			st_next.matchCnt = '0;
			st_next.locked = 1'b0;
			st_next.idleRun = '0;
			st_next.onesRun = '0;
			st_next.rxSt = fepcs_pkg::RX_IDLE;
			st_next.rxDv = 1'b0;
			st_next.rxEr = 1'b0;
			st_next.pendDv = 1'b0;
			st_next.pendEr = 1'b0;
		end else if (bitStrobe) begin
			st_next.nrziPrev = st_reg.dataSync[1];
			st_next.win = winNew;

			// Descrambler acquisition and hold supervision
			if (!st_reg.locked) begin
				st_next.lfsr = {st_reg.lfsr[9:0], ~nrz};
				if (scrSeq == ~nrz) begin
					st_next.matchCnt = st_reg.matchCnt + 1'b1;
				end else begin
					st_next.matchCnt = '0;
				end
				if (st_reg.matchCnt == fepcs_pkg::LOCK_BITS - 6'h1 && scrSeq == ~nrz) begin
					st_next.locked = 1'b1;
					st_next.holdCnt = HOLD_LAST;
					st_next.idleRun = '0;
				end
			end else begin
				st_next.lfsr = {st_reg.lfsr[9:0], scrSeq};
				st_next.idleRun = ud ? st_reg.idleRun + 1'b1 : 6'h0;
				if (ud && st_reg.idleRun == fepcs_pkg::HOLD_IDLE_BITS - 6'h1) begin
					st_next.holdCnt = HOLD_LAST;
					holdLoad = 1'b1;
					st_next.idleRun = '0;
				end
			end

			// Run of ones ahead of a carrier, only on usable data
			if (!(st_reg.locked || bypassDescrambler) || !ud) begin
				st_next.onesRun = '0;
			end else if (st_reg.onesRun != fepcs_pkg::IDLE_PREFIX_BITS) begin
				st_next.onesRun = st_reg.onesRun + 1'b1;
			end

			// Free-running group counter, forced on alignment
			st_next.bitCnt = groupDone ? 3'h0 : st_reg.bitCnt + 1'b1;
			if (groupDone) begin
				st_next.codeOut = group;
				st_next.codeStrobe = 1'b1;
				st_next.prevGroup = group;
			end

			unique case (st_reg.rxSt)
				fepcs_pkg::RX_IDLE: begin
					if (st_reg.linkUp && !bypassDecoder && !ud
							&& st_reg.onesRun == fepcs_pkg::IDLE_PREFIX_BITS) begin
						st_next.rxSt = fepcs_pkg::RX_CARRIER;
						st_next.carrCnt = '0;
					end
				end
				fepcs_pkg::RX_CARRIER: begin
					st_next.carrCnt = st_reg.carrCnt + 1'b1;
					if (st_reg.carrCnt == fepcs_pkg::CARRIER_LAST_BIT) begin
						st_next.bitCnt = 3'h0;
						st_next.prevGroup = group;
						if (winNew == {fepcs_pkg::CODE_J, fepcs_pkg::CODE_K}) begin
							st_next.rxSt = fepcs_pkg::RX_FRAME;
							st_next.rxd = fepcs_pkg::PREAMBLE_NIBBLE;
							st_next.rxDv = 1'b1;
							st_next.rxEr = 1'b0;
							st_next.pendRxd = fepcs_pkg::PREAMBLE_NIBBLE;
							st_next.pendDv = 1'b1;
							st_next.pendEr = 1'b0;
						end else begin
							st_next.rxSt = fepcs_pkg::RX_BAD;
							st_next.fcCount = st_reg.fcCount + 1'b1;
							st_next.rxd = fepcs_pkg::BAD_SSD_NIBBLE;
							st_next.rxDv = 1'b0;
							st_next.rxEr = 1'b1;
						end
					end
				end
				fepcs_pkg::RX_FRAME: begin
					if (groupDone) begin
						st_next.rxd = st_reg.pendRxd;
						st_next.rxDv = st_reg.pendDv;
						st_next.rxEr = st_reg.pendEr;
						if ((group == fepcs_pkg::CODE_R && st_reg.prevGroup == fepcs_pkg::CODE_T)
								|| (group == fepcs_pkg::CODE_I
								&& st_reg.prevGroup == fepcs_pkg::CODE_I)) begin
							st_next.rxSt = fepcs_pkg::RX_IDLE;
							st_next.rxDv = 1'b0;
							st_next.rxEr = 1'b0;
							st_next.pendDv = 1'b0;
							st_next.pendEr = 1'b0;
						end else begin
							st_next.pendRxd = decNibble;
							st_next.pendDv = 1'b1;
							st_next.pendEr = decInvalid && group != fepcs_pkg::CODE_T
								&& group != fepcs_pkg::CODE_R;
						end
					end
				end
				fepcs_pkg::RX_BAD: begin
					if (groupDone) begin
						st_next.rxd = fepcs_pkg::BAD_SSD_NIBBLE;
						st_next.rxEr = 1'b1;
						if (group == fepcs_pkg::CODE_I && st_reg.prevGroup == fepcs_pkg::CODE_I) begin
							st_next.rxSt = fepcs_pkg::RX_IDLE;
							st_next.rxEr = 1'b0;
							st_next.rxd = 4'h0;
							st_next.fcEvent = 1'b1;
						end
					end
				end
			endcase

			// Hold timer expiry forces reacquisition
			if (st_reg.locked && st_reg.holdCnt == '0) begin
				st_next.locked = 1'b0;
				st_next.lfsr = fepcs_pkg::LFSR_RESET;
				st_next.matchCnt = '0;
				st_next.idleRun = '0;
			end
		end

		// Hold timer counts core clocks while locked
		if (sd && st_reg.locked && st_next.locked && st_reg.holdCnt != '0 && !holdLoad) begin
			st_next.holdCnt = st_reg.holdCnt - 1'b1;
		end

		// Receive clock high for the second part of each group
		st_next.rxClk = st_next.bitCnt >= 3'h2;
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_reg <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign rxClk = st_reg.rxClk;
	assign rxd = st_reg.rxd;
	assign rxDv = st_reg.rxDv;
	assign rxEr = st_reg.rxEr;
	assign codeOut = st_reg.codeOut;
	assign codeStrobe = st_reg.codeStrobe;
	assign descramblerLocked = st_reg.locked;
	assign linkUp = st_reg.linkUp;
	assign falseCarrierCount = st_reg.fcCount;
	assign falseCarrierEvent = st_reg.fcEvent;
	assign eqLevelOut = st_reg.eqOut;
endmodule

// *** fepcs_rx_dummy_guard.sv ***
// Holds no logic of its own

// *** fepcs_rx_props.sv ***
// Port-level assertions for the receive coding sublayer
`timescale 1ns/100ps
module fepcs_rx_props #(
	parameter int LINK_UP_CYCLES = fepcs_pkg::LINK_UP_CYCLES,
	parameter int HOLD_CYCLES = fepcs_pkg::HOLD_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic signalDetect,
	input wire logic [fepcs_pkg::CFG_WIDTH-1:0] codingSublayerConfig,
	input wire logic bypassDescrambler,
	input wire logic [3:0] rxd,
	input wire logic rxDv,
	input wire logic rxEr,
	input wire logic codeStrobe,
	input wire logic descramblerLocked,
	input wire logic linkUp,
	input wire logic [fepcs_pkg::FC_WIDTH-1:0] falseCarrierCount,
	input wire logic falseCarrierEvent
);
	logic sdOn;
	logic lockGate;
	int sdCnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Effective signal detect and lock gate for link entry
	assign sdOn = signalDetect | codingSublayerConfig[fepcs_pkg::CFG_FORCE_SD_BIT];
	assign lockGate = codingSublayerConfig[fepcs_pkg::CFG_LOCK_FOR_LINK_BIT] & ~bypassDescrambler;
	// Run length of effective signal detect
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sdCnt <= 0;
		end else if (!sdOn) begin
			sdCnt <= 0;
		end else if (sdCnt < LINK_UP_CYCLES) begin
			sdCnt <= sdCnt + 1;
		end
	end
	a_link_needs_time: assert property (
		$rose(linkUp) |-> sdCnt >= LINK_UP_CYCLES) else $error("link up too early");
	a_link_lock_gate: assert property (
		$rose(linkUp) && lockGate |-> descramblerLocked) else $error("link up without lock");
	a_link_drop_loss: assert property (
		!sdOn |-> ##[1:4] !linkUp) else $error("link kept after signal loss");
	a_lock_clear_loss: assert property (
		!sdOn |-> ##[1:4] !descramblerLocked) else $error("lock kept after signal loss");
	a_strobe_spacing: assert property (
		codeStrobe |=> (!codeStrobe)[*8]) else $error("group strobes too close");
	a_fc_count_step: assert property (
		!$past(rst) && $changed(falseCarrierCount) |->
		falseCarrierCount == $past(falseCarrierCount) + 16'h0001) else $error("count step not one");
	a_fc_count_err: assert property (
		!$past(rst) && $changed(falseCarrierCount) |->
		rxEr && !rxDv && rxd == fepcs_pkg::BAD_SSD_NIBBLE) else $error("count without error");
	a_fc_event_end: assert property (
		falseCarrierEvent |-> !rxEr && $past(rxEr) ##1 !falseCarrierEvent) else $error("bad event");
	a_bad_nibble_err: assert property (
		rxEr && !rxDv |-> rxd == fepcs_pkg::BAD_SSD_NIBBLE) else $error("bad start nibble wrong");
	a_no_frame_down: assert property (
		(!linkUp)[*2] |-> !rxDv) else $error("data valid while link down");
endmodule
bind fepcs_rx fepcs_rx_props #(
	.LINK_UP_CYCLES(LINK_UP_CYCLES),
	.HOLD_CYCLES(HOLD_CYCLES)
) props (.core_clk, .rst, .signalDetect, .codingSublayerConfig, .bypassDescrambler, .rxd, .rxDv,
	.rxEr, .codeStrobe, .descramblerLocked, .linkUp, .falseCarrierCount, .falseCarrierEvent);

// *** fepcs_mac_model.sv ***
// MAC-side receive model collecting nibbles from the MII-style outputs
`timescale 1ns/100ps
module fepcs_mac_model (
	input wire logic rxClk,
	input wire logic [3:0] rxd,
	input wire logic rxDv,
	input wire logic rxEr,
	output int nibCount,
	output logic [63:0] nibHist,
	output int errCount,
	output logic [3:0] errNibble
);
	// Start empty
	initial begin
		nibCount = 0;
		errCount = 0;
		nibHist = '0;
		errNibble = '0;
	end
	// Sample on the receive clock rising edge
	always @(posedge rxClk) begin
		if (rxDv === 1'b1) begin
			nibCount <= nibCount + 1;
			nibHist <= {nibHist[59:0], rxd};
		end
		if (rxEr === 1'b1) begin
			errCount <= errCount + 1;
			errNibble <= rxd;
		end
	end
endmodule

// *** fepcs_rx_bench.sv ***
// Self-checking bench for the receive coding sublayer
`timescale 1ns/100ps
module fepcs_rx_bench;
	localparam int LINK_CYC = 50;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic lineClk = 1'b0;
	logic lineData = 1'b0;
	logic signalDetect = 1'b0;
	logic [fepcs_pkg::CFG_WIDTH-1:0] codingSublayerConfig = '0;
	logic bypassDescrambler = 1'b1;
	logic bypassDecoder = 1'b0;
	logic [7:0] eqLevel = 8'h5a;
	logic rxClk, rxDv, rxEr, codeStrobe, descramblerLocked, linkUp, falseCarrierEvent;
	logic [3:0] rxd, errNibble;
	logic [4:0] codeOut;
	logic [15:0] falseCarrierCount, fc;
	logic [7:0] eqLevelOut;
	logic [63:0] nibHist;
	logic nrziLevel = 1'b0;
	logic scramble = 1'b0;
	logic [10:0] lfsr = 11'h5a3;
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;
	int evCount = 0;
	int nibCount, errCount, nb, eb, ev;
	logic [4:0] dataCode [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	fepcs_rx #(.LINK_UP_CYCLES(LINK_CYC), .HOLD_CYCLES(1000)) dut (.core_clk, .rst, .lineClk,
		.lineData, .signalDetect, .codingSublayerConfig, .bypassDescrambler, .bypassDecoder,
		.eqLevel, .rxClk, .rxd, .rxDv, .rxEr, .codeOut, .codeStrobe, .descramblerLocked, .linkUp,
		.falseCarrierCount, .falseCarrierEvent, .eqLevelOut);
	fepcs_mac_model mac (.rxClk, .rxd, .rxDv, .rxEr, .nibCount, .nibHist, .errCount, .errNibble);
	// Core clock
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	// Cycle ceiling and event pulse count
	always @(posedge core_clk) begin
		cycles++;
		if (falseCarrierEvent === 1'b1) evCount++;
		if (cycles == 20000) begin
			failures++;
			$display("BAD %0t timeout", $time);
			stop_test();
		end
	end
	// One line bit: scrambled optionally, NRZI coded, 8 core cycles per bit
	task automatic send_bit(input logic b);
		logic n;
		n = lfsr[10] ^ lfsr[8];
		lfsr = {lfsr[9:0], n};
		nrziLevel = nrziLevel ^ b ^ (scramble & n);
		lineData <= nrziLevel;
		lineClk <= 1'b0;
		repeat (4) @(posedge core_clk);
		lineClk <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask
	task automatic send_group(input logic [4:0] g);
		for (int i = 4; i >= 0; i--) send_bit(g[i]);
	endtask
	task automatic send_idle(input int n);
		repeat (n) send_group(fepcs_pkg::CODE_I);
	endtask
	task automatic send_frame(input int n);
		send_idle(12);
		send_group(fepcs_pkg::CODE_J);
		send_group(fepcs_pkg::CODE_K);
		for (int i = 0; i < n; i++) send_group(dataCode[i]);
		send_group(fepcs_pkg::CODE_T);
		send_group(fepcs_pkg::CODE_R);
		send_idle(3);
	endtask
	task automatic check_val(input logic [63:0] got, input logic [63:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic check_flag(input logic got, input logic exp, input string what);
		check_val({63'h0, got}, {63'h0, exp}, what);
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		check_flag(linkUp, 1'b0, "link after reset");
		check_val(falseCarrierCount, 64'h0, "count after reset");
		codingSublayerConfig <= 16'h0002;
		repeat (LINK_CYC - 10) @(posedge core_clk);
		check_flag(linkUp, 1'b0, "link early");
		repeat (20) @(posedge core_clk);
		check_flag(linkUp, 1'b1, "link up");
		check_val(eqLevelOut, 64'h5a, "eq level");
		$display("done link bring-up");
		nb = nibCount;
		send_frame(16);
		check_val(nibCount - nb, 64'd18, "nibble count");
		check_val(nibHist, 64'h0123456789abcdef, "nibbles");
		$display("done frame decode");
		fc = falseCarrierCount;
		eb = errCount;
		ev = evCount;
		nb = nibCount;
		send_idle(4);
		send_group(dataCode[2]);
		send_group(dataCode[2]);
		send_idle(3);
		check_val(falseCarrierCount, fc + 16'h0001, "false carrier count");
		check_val(errNibble, 64'he, "error nibble");
		check_flag(errCount > eb, 1'b1, "error seen");
		check_val(evCount - ev, 64'd1, "event pulses");
		check_val(nibCount - nb, 64'd0, "no data on bad start");
		eb = errCount;
		dataCode[0] = fepcs_pkg::CODE_H;
		send_frame(1);
		dataCode[0] = 5'h1e;
		check_flag(errCount > eb, 1'b1, "halt flagged");
		$display("done bad start");
		bypassDecoder <= 1'b1;
		nb = nibCount;
		send_frame(4);
		check_val(nibCount - nb, 64'd0, "bypass data");
		check_val(codeOut, 64'h1f, "raw group");
		bypassDecoder <= 1'b0;
		$display("done decoder bypass");
		codingSublayerConfig <= 16'h0000;
		repeat (8) @(posedge core_clk);
		check_flag(linkUp, 1'b0, "link after loss");
		codingSublayerConfig <= 16'h0100;
		signalDetect <= 1'b1;
		bypassDescrambler <= 1'b0;
		scramble = 1'b1;
		send_idle(6);
		check_flag(linkUp, 1'b0, "link without lock");
		send_idle(18);
		check_flag(descramblerLocked, 1'b1, "lock");
		check_flag(linkUp, 1'b1, "link with lock");
		send_idle(14);
		repeat (16) send_group(5'h00);
		check_flag(descramblerLocked, 1'b1, "lock held");
		repeat (10) send_group(5'h00);
		check_flag(descramblerLocked, 1'b0, "lock lost");
		check_flag(linkUp, 1'b1, "link kept");
		$display("done descrambler");
		stop_test();
	end
endmodule
